// [hw/fotc_defines.svh]
// Offsets, field positions, reset values and timing counts of the diagnostics registers.
// Assumes inclusion by bare name from the package and the register bank module.
`ifndef FOTC_DEFINES_SVH
`define FOTC_DEFINES_SVH

`define FOTC_PAGE_DIAG        3'h2
`define FOTC_OFS_FREQ         5'h15
`define FOTC_OFS_CABLE        5'h16

`define FOTC_FREQ_POLL_BIT    15
`define FOTC_FREQ_SEL_BIT     8
`define FOTC_FREQ_RESULT_MSB  7
`define FOTC_FREQ_RESET       16'h0000

`define FOTC_CBL_ENABLE_BIT   15
`define FOTC_CBL_FAST_BIT     14
`define FOTC_CBL_PAIR_BIT     13
`define FOTC_CBL_RXCH_BIT     12
`define FOTC_CBL_SEND_BIT     11
`define FOTC_CBL_WIDTH_MSB    10
`define FOTC_CBL_WIDTH_LSB    8
`define FOTC_CBL_RESET        16'h0020

`define FOTC_CLK_PERIOD_NS    100
`define FOTC_POLL_WAIT_CYC    4'h3

`endif

// [hw/fotc_diag_regs.sv]
// Link diagnostics register bank: frequency offset readout and cable test control.
// Assumes a single-cycle management register port on clk and a DSP with req/ack handshake.
//
// How it works
// - A poll with the select bit low fetches the long-term offset from the DSP.
// - A poll with the select bit high fetches the offset plus short-term correction.
// - The poll trigger is write-only and always reads back as zero.
// - Bits 14 to 9 of the offset register ignore writes and read as zero.
// - The result is an 8-bit two's-complement value passed unchanged from the DSP.
// - The result is read-only, resets to zero and changes only on a polled load.
// - The enable bit, reset low, forces the analog front end into cable test state.
// - With the fast bit set, pulses go through the 100 Mb transmitter in 8 ns clocks.
// - Successive fast-transmitter pulses alternate in polarity.
// - With the fast bit clear, the 10 Mb link pulse generator sends 50 or 100 ns.
// - The pair select bit sends pulses on the transmit pair at 0, receive pair at 1.
// - The width field in bits 10 to 8 gives the pulse width in transmitter clocks.
//
// Limitations
// The result is only as fresh as the last poll; software polls again to refresh it.
// A poll written while another is in flight is dropped, though its select bit is kept.
// A send written while a pulse is in flight is dropped; the busy send bit reads as one.
// A send written with the enable bit low never starts and stays pending until reset.
// The slow path clamps any width above two clocks to the full link pulse.
// A width of zero sends no pulse but still completes, for baseline measurement.
// Every output is registered; all but dsp_req and dsp_sel_control trail the internal state by one clock.
// The DSP acknowledge and value come from logic on this clock and are not synchronised.
// Writes and reads on any page other than the diagnostics page are ignored here.
`timescale 1ns/1ps
`include "fotc_defines.svh"

module fotc_diag_regs
    import fotc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire fotc_req_t   req,
    output logic [15:0]      rdata,
    output logic             dsp_req,
    output logic             dsp_sel_control,
    input  wire logic        dsp_ack,
    input  wire logic [7:0]  dsp_value,
    output logic             diag_mode,
    output logic             pulse_active,
    output logic             pulse_negative,
    output logic             pulse_fast,
    output logic             pulse_pair,
    output logic             capture_rx_pair
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    logic hit_freq;
    logic hit_cable;
    logic wr_freq;
    logic wr_cable;
    logic rd_freq;
    logic rd_cable;
    logic wr_poll;
    logic wr_sel;
    logic wr_send;

    // Registers answer only on the diagnostics page.
    assign hit_freq  = (req.page == `FOTC_PAGE_DIAG) && (req.addr == `FOTC_OFS_FREQ);
    assign hit_cable = (req.page == `FOTC_PAGE_DIAG) && (req.addr == `FOTC_OFS_CABLE);

    // Qualified strobes; any other page or address leaves every register untouched.
    assign wr_freq  = req.wr && hit_freq;
    assign wr_cable = req.wr && hit_cable;
    assign rd_freq  = req.rd && hit_freq;
    assign rd_cable = req.rd && hit_cable;

    // Write fields that start an action or pick a source rather than being stored whole.
    assign wr_poll = req.wdata[`FOTC_FREQ_POLL_BIT];
    assign wr_sel  = req.wdata[`FOTC_FREQ_SEL_BIT];
    assign wr_send = req.wdata[`FOTC_CBL_SEND_BIT];

    // ------------------------------------------------------------------
    // Frequency offset readout
    // ------------------------------------------------------------------

    fotc_poll_state_t poll_q, poll_d;
    logic             sel_q, sel_d;
    logic             poll_sel_q, poll_sel_d;
    logic [7:0]       result_q, result_d;
    logic             dreq_q, dreq_d;
    logic [7:0]       cap_q, cap_d;

    // Poll sequencer: latch the selection, request the DSP, load the result whole.
    // The value is caught into a holding register on the acknowledge and copied one
    // clock later, so a read landing on the acknowledge edge still sees the old byte.
    // Only the select bit of a write is stored; bits 14 to 9 have no storage at all.
    always_comb begin
        poll_d     = poll_q;
        sel_d      = sel_q;
        poll_sel_d = poll_sel_q;
        result_d   = result_q;
        dreq_d     = dreq_q;
        cap_d      = cap_q;
        if (wr_freq) begin
            sel_d = wr_sel;
        end
        case (poll_q)
            FOTC_IDLE: begin
                if (wr_freq && wr_poll) begin
                    // Selection is taken from the same write as the trigger.
                    poll_sel_d = wr_sel;
                    dreq_d     = 1'b1;
                    poll_d     = FOTC_WAIT;
                end
            end
            FOTC_WAIT: begin
                if (dsp_ack) begin
                    cap_d  = dsp_value;
                    dreq_d = 1'b0;
                    poll_d = FOTC_LOAD;
                end
            end
            FOTC_LOAD: begin
                result_d = cap_q;
                poll_d   = FOTC_IDLE;
            end
            default: begin
                poll_d = FOTC_IDLE;
            end
        endcase
    end

    // Poll sequencer registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            poll_q     <= FOTC_IDLE;
            sel_q      <= 1'b0;
            poll_sel_q <= 1'b0;
            result_q   <= 8'(`FOTC_FREQ_RESET);
            dreq_q     <= 1'b0;
            cap_q      <= 8'h00;
        end else begin
            poll_q     <= poll_d;
            sel_q      <= sel_d;
            poll_sel_q <= poll_sel_d;
            result_q   <= result_d;
            dreq_q     <= dreq_d;
            cap_q      <= cap_d;
        end
    end

    // ------------------------------------------------------------------
    // Cable test control
    // ------------------------------------------------------------------

    logic [15:0]     cable_q, cable_d;
    logic            send_q, send_d;
    logic            start_q, start_d;
    logic            pdone;
    fotc_pulse_cmd_t pcmd;

    // Control register; the send bit self-clears when the pulse is done.
    // The send bit is kept apart from the stored word so that a write can never
    // cancel a pulse in flight, and a second send while one is busy is dropped.
    // A send written with the enable bit low never starts and stays set until reset.
    always_comb begin
        cable_d = cable_q;
        send_d  = send_q;
        start_d = 1'b0;
        if (wr_cable) begin
            cable_d = req.wdata;
            cable_d[`FOTC_CBL_SEND_BIT] = 1'b0;
            if (wr_send && !send_q) begin
                send_d  = 1'b1;
                start_d = 1'b1;
            end
        end
        if (pdone) begin
            send_d = 1'b0;
        end
    end

    // Cable control registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cable_q <= `FOTC_CBL_RESET;
            send_q  <= 1'b0;
            start_q <= 1'b0;
        end else begin
            cable_q <= cable_d;
            send_q  <= send_d;
            start_q <= start_d;
        end
    end

    // Pulse command taken from the stored control word.
    assign pcmd.fast  = cable_q[`FOTC_CBL_FAST_BIT];
    assign pcmd.pair  = cable_q[`FOTC_CBL_PAIR_BIT];
    assign pcmd.width = cable_q[`FOTC_CBL_WIDTH_MSB:`FOTC_CBL_WIDTH_LSB];

    // Raw sequencer state; it is registered once more before it reaches the pins.
    logic pact, pneg, pfast, ppair;

    fotc_pulse_gen u_pulse (
        .clk            (clk),
        .reset_n        (reset_n),
        .start          (start_q && cable_q[`FOTC_CBL_ENABLE_BIT]),
        .cmd            (pcmd),
        .pulse_active   (pact),
        .pulse_negative (pneg),
        .pulse_fast     (pfast),
        .pulse_pair     (ppair),
        .done           (pdone)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    logic [15:0] rdata_q, rdata_d;

    // Read mux; poll bit and reserved bits return zero, and so does an idle cycle.
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_freq) begin
            rdata_d[`FOTC_FREQ_SEL_BIT] = sel_q;
            rdata_d[`FOTC_FREQ_RESULT_MSB:0] = result_q;
        end else if (rd_cable) begin
            rdata_d = cable_q;
            rdata_d[`FOTC_CBL_SEND_BIT] = send_q;
        end
    end

    // Read data register; the word stands for exactly one cycle after the read edge,
    // so a master that samples late sees zero rather than a stale word.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin-side outputs
    // ------------------------------------------------------------------

    logic diag_mode_q, diag_mode_d;
    logic pact_q,      pact_d;
    logic pneg_q,      pneg_d;
    logic pfast_q,     pfast_d;
    logic ppair_q,     ppair_d;
    logic rx_pair_q,   rx_pair_d;
    logic dsp_req_q,   dsp_req_d;
    logic dsp_sel_q,   dsp_sel_d;

    // Next values of the pin-side outputs; each one but dsp_req and dsp_sel_control trails its source by one clock,
    // which keeps combinational glitches of the sequencers off the pins.
    always_comb begin
        diag_mode_d = cable_q[`FOTC_CBL_ENABLE_BIT];
        pact_d      = pact;
        pneg_d      = pneg;
        pfast_d     = pfast;
        ppair_d     = ppair;
        rx_pair_d   = cable_q[`FOTC_CBL_RXCH_BIT];
        dsp_req_d   = dreq_d;
        dsp_sel_d   = poll_sel_d;
    end

    // Output registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            diag_mode_q <= 1'b0;
            pact_q      <= 1'b0;
            pneg_q      <= 1'b0;
            pfast_q     <= 1'b0;
            ppair_q     <= 1'b0;
            rx_pair_q   <= 1'b0;
            dsp_req_q   <= 1'b0;
            dsp_sel_q   <= 1'b0;
        end else begin
            diag_mode_q <= diag_mode_d;
            pact_q      <= pact_d;
            pneg_q      <= pneg_d;
            pfast_q     <= pfast_d;
            ppair_q     <= ppair_d;
            rx_pair_q   <= rx_pair_d;
            dsp_req_q   <= dsp_req_d;
            dsp_sel_q   <= dsp_sel_d;
        end
    end

    // Every output comes straight from a flip-flop.
    assign rdata           = rdata_q;
    assign diag_mode       = diag_mode_q;
    assign pulse_active    = pact_q;
    assign pulse_negative  = pneg_q;
    assign pulse_fast      = pfast_q;
    assign pulse_pair      = ppair_q;
    assign capture_rx_pair = rx_pair_q;
    assign dsp_req         = dsp_req_q;
    assign dsp_sel_control = dsp_sel_q;

endmodule : fotc_diag_regs

// [hw/fotc_pkg.sv]
// Types shared by the diagnostics register bank and its pulse sequencer.
// Assumes the defines header is on the include path.
`include "fotc_defines.svh"

package fotc_pkg;

    // Register access request from the management interface.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  page;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } fotc_req_t;

    // Cable test pulse command handed to the pulse sequencer.
    typedef struct packed {
        logic       fast;
        logic       pair;
        logic [2:0] width;
    } fotc_pulse_cmd_t;

    // Poll sequencer states.
    typedef enum logic [2:0] {
        FOTC_IDLE  = 3'b001,
        FOTC_WAIT  = 3'b010,
        FOTC_LOAD  = 3'b100
    } fotc_poll_state_t;

    // Pulse sequencer states.
    typedef enum logic [2:0] {
        FOTC_P_IDLE = 3'b001,
        FOTC_P_HIGH = 3'b010,
        FOTC_P_DONE = 3'b100
    } fotc_pulse_state_t;

endpackage : fotc_pkg

// [hw/fotc_pulse_gen.sv]
// Cable test pulse sequencer: times one pulse and tracks polarity on the fast path.
// Assumes clk and reset_n of the register bank and a one-cycle start strobe.
`timescale 1ns/1ps

module fotc_pulse_gen
    import fotc_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            start,
    input  wire fotc_pulse_cmd_t cmd,
    output logic                 pulse_active,
    output logic                 pulse_negative,
    output logic                 pulse_fast,
    output logic                 pulse_pair,
    output logic                 done
);

    fotc_pulse_state_t state_q, state_d;
    logic [2:0]        cnt_q, cnt_d;
    logic              neg_q, neg_d;
    logic              fast_q, fast_d;
    logic              pair_q, pair_d;
    logic              done_q, done_d;

    // Next-state logic; the width counts clocks of the selected transmitter.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        neg_d   = neg_q;
        fast_d  = fast_q;
        pair_d  = pair_q;
        done_d  = 1'b0;
        case (state_q)
            FOTC_P_IDLE: begin
                if (start) begin
                    fast_d = cmd.fast;
                    pair_d = cmd.pair;
                    // Slow path only has a half or full link pulse.
                    cnt_d  = cmd.fast ? cmd.width : ((cmd.width > 3'h2) ? 3'h2 : cmd.width);
                    if (cmd.width == 3'h0) begin
                        state_d = FOTC_P_DONE;
                    end else begin
                        state_d = FOTC_P_HIGH;
                    end
                end
            end
            FOTC_P_HIGH: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h1) begin
                    state_d = FOTC_P_DONE;
                    if (fast_q) begin
                        neg_d = ~neg_q;
                    end
                end
            end
            FOTC_P_DONE: begin
                done_d  = 1'b1;
                state_d = FOTC_P_IDLE;
            end
            default: begin
                state_d = FOTC_P_IDLE;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= FOTC_P_IDLE;
            cnt_q   <= 3'h0;
            neg_q   <= 1'b0;
            fast_q  <= 1'b0;
            pair_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            neg_q   <= neg_d;
            fast_q  <= fast_d;
            pair_q  <= pair_d;
            done_q  <= done_d;
        end
    end

    assign pulse_active   = (state_q == FOTC_P_HIGH);
    assign pulse_negative = neg_q;
    assign pulse_fast     = fast_q;
    assign pulse_pair     = pair_q;
    assign done           = done_q;

endmodule : fotc_pulse_gen

// [verification/fotc_diag_monitor.sv]
// Concurrent checks on the ports of the diagnostics register bank.
// Assumes one clock and an asynchronous active-low reset, bound to fotc_diag_regs.
`timescale 1ns/1ps

module fotc_diag_monitor
    import fotc_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire fotc_req_t   req,
    input wire logic [15:0] rdata,
    input wire logic        dsp_req,
    input wire logic        dsp_sel_control,
    input wire logic        dsp_ack,
    input wire logic        diag_mode,
    input wire logic        capture_rx_pair
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Request shapes
    // ----------------------------------------
    // A poll write only counts once the previous poll has fully settled.
    sequence s_poll_wr;
        req.wr && req.page == 3'h2 && req.addr == 5'h15 && req.wdata[15]
            && !dsp_req && !$past(dsp_req) && !$past(dsp_req, 2);
    endsequence
    sequence s_cbl_wr;
        req.wr && req.page == 3'h2 && req.addr == 5'h16;
    endsequence
    // A cable write, one clock on: its bits reach the pins at the following edge.
    sequence s_cbl_aged;
        s_cbl_wr ##1 1'b1;
    endsequence
    sequence s_frd;
        req.rd && req.page == 3'h2 && req.addr == 5'h15;
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_poll_starts: assert property (s_poll_wr |=> dsp_req)
        else $error("poll write did not raise dsp_req");
    chk_poll_select: assert property (s_poll_wr |=> dsp_sel_control == $past(req.wdata[8]))
        else $error("dsp_sel_control differs from written select");
    chk_req_holds: assert property (dsp_req && !dsp_ack |=> dsp_req)
        else $error("dsp_req dropped before acknowledge");
    chk_req_drops: assert property (dsp_req && dsp_ack |=> !dsp_req)
        else $error("dsp_req stayed after acknowledge");
    chk_poll_bit: assert property (s_frd |=> !rdata[15])
        else $error("poll trigger read back nonzero");
    chk_rsvd_zero: assert property (s_frd |=> rdata[14:9] == 6'h00)
        else $error("reserved offset bits read nonzero");
    chk_enable_follows: assert property (s_cbl_aged |=>
            diag_mode == $past(req.wdata[15], 2))
        else $error("diag_mode differs from enable bit");
    chk_rx_follows: assert property (s_cbl_aged |=>
            capture_rx_pair == $past(req.wdata[12], 2))
        else $error("capture_rx_pair differs from written bit");
    chk_rdata_idle: assert property (!req.rd |=> rdata == 16'h0000)
        else $error("rdata nonzero without a read");
endmodule : fotc_diag_monitor

bind fotc_diag_regs fotc_diag_monitor u_mon (.clk, .reset_n, .req, .rdata, .dsp_req,
    .dsp_sel_control, .dsp_ack, .diag_mode, .capture_rx_pair);

// [verification/offset_result_and_cable_test_ctrl_test.sv]
// Self-checking bench for the diagnostics register bank.
// Assumes the bench plays both management master and DSP, driving at falling edges.
`timescale 1ns/1ps

module offset_result_and_cable_test_ctrl_test
    import fotc_pkg::*;
;
    logic        clk, reset_n, dsp_ack, dsp_req, dsp_sel_control, diag_mode;
    logic        pulse_active, pulse_negative, pulse_fast, pulse_pair, capture_rx_pair;
    logic [7:0]  dsp_value;
    logic [15:0] rdata, d;
    fotc_req_t   req;
    int          mismatches, cmp_count, cyc;

    fotc_diag_regs DUT (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
        .dsp_req(dsp_req), .dsp_sel_control(dsp_sel_control), .dsp_ack(dsp_ack),
        .dsp_value(dsp_value), .diag_mode(diag_mode), .pulse_active(pulse_active),
        .pulse_negative(pulse_negative), .pulse_fast(pulse_fast),
        .pulse_pair(pulse_pair), .capture_rx_pair(capture_rx_pair));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compares and reports one value.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One register write, strobe held for one edge.
    task automatic wr(input logic [2:0] pg, input logic [4:0] a, input logic [15:0] v);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: v};
        @(negedge clk);
        req.wr = 1'b0;
    endtask : wr

    // One register read; the data stands for the cycle after the read edge.
    task automatic rd(input logic [2:0] pg, input logic [4:0] a);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 16'h0000};
        @(negedge clk);
        req.rd = 1'b0;
        d = rdata;
    endtask : rd

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Poll with a slow DSP; the old result must stay until the load.
    task automatic t_poll(input logic sel, input logic [7:0] val, input logic [7:0] old);
        wr(3'h2, 5'h15, {1'b1, 6'h3F, sel, 8'h55});
        chk({14'h0, dsp_req, dsp_sel_control}, {14'h0, 1'b1, sel}, "poll start");
        rd(3'h2, 5'h15);
        chk(d, {7'h00, sel, old}, "old result kept");
        @(negedge clk);
        dsp_value = val;
        dsp_ack = 1'b1;
        @(negedge clk);
        dsp_ack = 1'b0;
        dsp_value = ~val;
        chk(16'(dsp_req), 16'h0000, "request dropped");
        repeat (2) @(negedge clk);
        rd(3'h2, 5'h15);
        chk(d, {7'h00, sel, val}, "polled result");
    endtask : t_poll

    // Starts one cable pulse and measures its kind and length.
    task automatic t_pulse(input logic [15:0] v, input logic neg, input int len);
        int n;
        wr(3'h2, 5'h16, v);
        @(negedge clk); // The pin follows the stored bit one clock later.
        chk(16'(diag_mode), 16'(v[15]), "enable");
        n = 0;
        while (pulse_active !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk({pulse_fast, pulse_negative, pulse_pair}, {v[14], neg, v[13]}, "kind");
        n = 0;
        while (pulse_active === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n), 16'(len), "pulse width");
        repeat (4) @(negedge clk);
        rd(3'h2, 5'h16);
        chk(d, v & 16'hF7FF, "send cleared");
    endtask : t_pulse

    // Other pages and addresses read zero and ignore writes.
    task automatic t_refuse;
        wr(3'h1, 5'h16, 16'h0000);
        rd(3'h2, 5'h16);
        chk(d, 16'hD220, "other page write");
        wr(3'h2, 5'h17, 16'hFFFF);
        rd(3'h2, 5'h17);
        chk(d, 16'h0000, "unmapped read");
        rd(3'h1, 5'h15);
        chk(d, 16'h0000, "other page read");
    endtask : t_refuse

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end

    // Resets, then runs every scenario in turn.
    initial begin
        req = '0;
        dsp_ack = 1'b0;
        dsp_value = 8'h00;
        reset_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        rd(3'h2, 5'h15);
        chk(d, 16'h0000, "offset reset");
        rd(3'h2, 5'h16);
        chk(d, 16'h0020, "cable reset");
        t_poll(1'b0, 8'h7F, 8'h00);
        t_poll(1'b1, 8'h80, 8'h7F);
        t_pulse(16'hAF20, 1'b0, 2);
        t_pulse(16'hDA20, 1'b0, 2);
        t_pulse(16'hDA20, 1'b1, 2);
        t_refuse();
        final_report();
    end
endmodule : offset_result_and_cable_test_ctrl_test
